/* File: pkg/modulator_phase_pkg.sv */
// Constants for the modulator snapshot and phase-delay register bank.
// Assumes a single core clock and a same-clock serial register front end.
package modulator_phase_pkg;
   localparam int unsigned NUM_CHANNELS = 8;
   localparam int unsigned NUM_PAIRS    = 4;
   localparam int unsigned COMP_BITS    = 4;
   localparam int unsigned ADDR_W       = 5;
   localparam int unsigned DATA_W       = 32;
   localparam int unsigned PHASE_W      = 24;
   localparam int unsigned DELAY_W      = 12;

   localparam logic [4:0] ADDR_SNAPSHOT    = 5'h08;
   localparam logic [4:0] ADDR_DELAY_UPPER = 5'h09;
   localparam logic [4:0] ADDR_DELAY_LOWER = 5'h0a;

   localparam int unsigned FIELD_HI_LSB = 12;
   localparam int unsigned FIELD_LO_LSB = 0;

   // Zero-volt pattern per channel group
   localparam logic [31:0] SNAPSHOT_RESET = 32'h33333333;
   localparam logic [23:0] PHASE_RESET    = 24'h000000;
   localparam logic [11:0] DELAY_ZERO     = 12'h000;
endpackage : modulator_phase_pkg

/* File: pkg/phase_link_if.sv */
// Carrier between the register bank and one pair-delay timer.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
`default_nettype none
interface phase_link_if;
   logic        tick;
   logic        restart;
   logic [11:0] delay;
   logic        fire;

   modport ctrl  (output tick, output restart, output delay, input fire);
   modport timer (input tick, input restart, input delay, output fire);
endinterface : phase_link_if
`default_nettype wire

/* File: hw/pair_delay_timer.sv */
// Counts modulator clock ticks after a restart and fires once for the
// lagging channel of a pair. Assumes tick is a one-cycle enable.
`timescale 1ns/1ps
`default_nettype none
module pair_delay_timer (
   // Clock and reset
   input  wire logic   core_clk,
   input  wire logic   sys_rst,
   // Link to the bank
   phase_link_if.timer link
);
   logic [11:0] remaining;
   logic        armed;
   logic        fire;

   assign link.fire = fire;

   // Code zero fires on the first tick, together with the reference
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         remaining <= modulator_phase_pkg::DELAY_ZERO;
         armed     <= 1'b0;
         fire      <= 1'b0;
      end else begin
         fire <= 1'b0;
         if (link.restart) begin
            remaining <= link.delay;
            armed     <= 1'b1;
         end else if (armed && link.tick) begin
            if (remaining == modulator_phase_pkg::DELAY_ZERO) begin
               fire  <= 1'b1;
               armed <= 1'b0;
            end else begin
               remaining <= remaining - 12'h001;
            end
         end
      end
   end
endmodule : pair_delay_timer
`default_nettype wire

/* File: hw/modulator_phase_regs.sv */
// Modulator snapshot and phase-delay registers of an eight-channel
// front end, with the restart sequencing that a phase write triggers.
// Assumes the serial front end, comparators and modulator clock enable
// all come from logic on core_clk.
`timescale 1ns/1ps
`default_nettype none
module modulator_phase_regs (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   // Register access from the serial front end
   input  wire logic [4:0]  reg_addr,
   input  wire logic        reg_wr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   output logic             reg_rvalid,
   // Modulators
   input  wire logic        modulator_clock,
   input  wire logic [31:0] comparator_bit,
   input  wire logic [7:0]  channel_active,
   // Converter control
   output logic      [7:0]  converter_reset,
   output logic      [7:0]  channel_start,
   output logic      [11:0] pair67_delay,
   output logic      [11:0] pair45_delay,
   output logic      [11:0] pair23_delay,
   output logic      [11:0] pair01_delay
);
   logic [31:0] modulator_snapshot;
   logic [23:0] delay_cfg_upper_pairs;
   logic [23:0] delay_cfg_lower_pairs;
   logic [7:0]  restart_mask;
   logic        restart;
   logic [11:0] pair_delay [4];
   logic [3:0]  pair_fire;
   logic [3:0]  ref_pending;
   logic [3:0]  ref_fire;
   logic        wr_snapshot;
   logic        wr_upper;
   logic        wr_lower;
   logic [31:0] next_rdata;

   assign wr_snapshot = reg_wr && (reg_addr == modulator_phase_pkg::ADDR_SNAPSHOT);
   assign wr_upper = reg_wr && (reg_addr == modulator_phase_pkg::ADDR_DELAY_UPPER);
   assign wr_lower = reg_wr && (reg_addr == modulator_phase_pkg::ADDR_DELAY_LOWER);

   // Fresh comparator data wins over a host write in the same cycle,
   // so the converters never run on a stale host pattern
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         modulator_snapshot <= modulator_phase_pkg::SNAPSHOT_RESET;
      end else if (modulator_clock) begin
         modulator_snapshot <= comparator_bit;
      end else if (wr_snapshot) begin
         modulator_snapshot <= reg_wdata;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         delay_cfg_upper_pairs <= modulator_phase_pkg::PHASE_RESET;
      end else if (wr_upper) begin
         delay_cfg_upper_pairs <= reg_wdata[23:0];
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         delay_cfg_lower_pairs <= modulator_phase_pkg::PHASE_RESET;
      end else if (wr_lower) begin
         delay_cfg_lower_pairs <= reg_wdata[23:0];
      end
   end

   // Delay fields, one per pair, lagging channel first
   always_comb begin
      pair_delay[0] = delay_cfg_lower_pairs[11:0];
      pair_delay[1] = delay_cfg_lower_pairs[23:12];
      pair_delay[2] = delay_cfg_upper_pairs[11:0];
      pair_delay[3] = delay_cfg_upper_pairs[23:12];
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pair67_delay <= modulator_phase_pkg::DELAY_ZERO;
         pair45_delay <= modulator_phase_pkg::DELAY_ZERO;
         pair23_delay <= modulator_phase_pkg::DELAY_ZERO;
         pair01_delay <= modulator_phase_pkg::DELAY_ZERO;
      end else begin
         pair67_delay <= pair_delay[3];
         pair45_delay <= pair_delay[2];
         pair23_delay <= pair_delay[1];
         pair01_delay <= pair_delay[0];
      end
   end

   // Restart pulse follows the write by one cycle; timers load new fields
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         restart         <= 1'b0;
         converter_reset <= 8'h00;
         restart_mask    <= 8'h00;
      end else begin
         restart         <= wr_upper || wr_lower;
         converter_reset <= (wr_upper || wr_lower) ? channel_active : 8'h00;
         if (wr_upper || wr_lower) begin
            restart_mask <= channel_active;
         end
      end
   end

   generate
      for (genvar p = 0; p < 4; p++) begin : g_pair
         phase_link_if link ();
         assign link.tick    = modulator_clock;
         assign link.restart = restart;
         assign link.delay   = pair_delay[p];
         assign pair_fire[p] = link.fire;

         pair_delay_timer u_timer (
            .core_clk (core_clk),
            .sys_rst  (sys_rst),
            .link     (link)
         );

         // Reference channel starts on the first tick after restart
         always_ff @(posedge core_clk or posedge sys_rst) begin
            if (sys_rst) begin
               channel_start[2*p+1] <= 1'b0;
               channel_start[2*p]   <= 1'b0;
            end else begin
               channel_start[2*p+1] <= ref_fire[p] && restart_mask[2*p+1];
               channel_start[2*p]   <= pair_fire[p] && restart_mask[2*p];
            end
         end
      end
   endgenerate

   // Reference starts are tracked separately so a nonzero delay still
   // launches the reference on the first tick; the extra stage lines it
   // up with the timer's registered fire, so code zero starts both at once
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ref_pending <= 4'h0;
         ref_fire    <= 4'h0;
      end else begin
         ref_fire <= (restart || !modulator_clock) ? 4'h0 : ref_pending;
         if (restart) begin
            ref_pending <= 4'hf;
         end else if (modulator_clock) begin
            ref_pending <= 4'h0;
         end
      end
   end

   always_comb begin
      next_rdata = 32'h00000000;
      unique case (reg_addr)
         modulator_phase_pkg::ADDR_SNAPSHOT:    next_rdata = modulator_snapshot;
         modulator_phase_pkg::ADDR_DELAY_UPPER: next_rdata = {8'h00, delay_cfg_upper_pairs};
         modulator_phase_pkg::ADDR_DELAY_LOWER: next_rdata = {8'h00, delay_cfg_lower_pairs};
         default:                               next_rdata = 32'h00000000;
      endcase
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata  <= 32'h00000000;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            reg_rdata <= next_rdata;
         end
      end
   end
endmodule : modulator_phase_regs
`default_nettype wire

/* File: testbench/modulator_phase_regs_asserts.sv */
// Port checker for the snapshot and phase-delay bank.
// Assumes it is bound onto modulator_phase_regs.
`timescale 1ns/1ps
`default_nettype none
module modulator_phase_regs_asserts (
   // Clock, reset and register port
   input wire logic        core_clk,
   input wire logic        sys_rst,
   input wire logic [4:0]  reg_addr,
   input wire logic        reg_wr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic        reg_rvalid,
   // Converter side
   input wire logic        modulator_clock,
   input wire logic [31:0] comparator_bit,
   input wire logic [7:0]  channel_active,
   input wire logic [7:0]  converter_reset,
   input wire logic [11:0] pair67_delay,
   input wire logic [11:0] pair45_delay,
   input wire logic [11:0] pair23_delay,
   input wire logic [11:0] pair01_delay
);
   logic [31:0] shadow;
   logic        ph_wr;
   assign ph_wr = reg_wr && (reg_addr == 5'h09 || reg_addr == 5'h0a);
   // Fresh comparator data beats a host write
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) shadow <= 32'h33333333;
      else if (modulator_clock) shadow <= comparator_bit;
      else if (reg_wr && reg_addr == 5'h08) shadow <= reg_wdata;
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   sequence s_phase_wr;
      ph_wr;
   endsequence
   chk_rvalid_timing: assert property (reg_rvalid == $past(reg_rd))
      else $error("read answer late");
   chk_snap_read: assert property (
      reg_rd && reg_addr == 5'h08 |=> reg_rdata == $past(shadow))
      else $error("snapshot read wrong");
   chk_unmapped_zero: assert property (
      reg_rd && (reg_addr < 5'h08 || reg_addr > 5'h0a) |=> reg_rdata == '0)
      else $error("unmapped read not zero");
   chk_narrow_regs: assert property (
      reg_rd && reg_addr != 5'h08 |=> reg_rdata[31:24] == 8'h00)
      else $error("upper byte not zero");
   chk_restart_mask: assert property (
      s_phase_wr |=> converter_reset == $past(channel_active))
      else $error("restart mask wrong");
   chk_restart_cause: assert property (
      converter_reset != 8'h00 |-> $past(ph_wr))
      else $error("restart without write");
   chk_upper_fields: assert property (
      reg_wr && reg_addr == 5'h09 |=> ##1
      {pair67_delay, pair45_delay} == $past(reg_wdata[23:0], 2))
      else $error("upper pair delays wrong");
   chk_lower_fields: assert property (
      reg_wr && reg_addr == 5'h0a |=> ##1
      {pair23_delay, pair01_delay} == $past(reg_wdata[23:0], 2))
      else $error("lower pair delays wrong");
endmodule : modulator_phase_regs_asserts
bind modulator_phase_regs modulator_phase_regs_asserts chk_u (
   .core_clk, .sys_rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
   .reg_rdata, .reg_rvalid, .modulator_clock, .comparator_bit,
   .channel_active, .converter_reset, .pair67_delay, .pair45_delay,
   .pair23_delay, .pair01_delay);
`default_nettype wire

/* File: testbench/host_model.sv */
// Host side of the register port, one-cycle strobes on falling edges.
// Assumes a read answer arrives one cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none
module host_model (
   // Clock and answer
   input  wire logic        core_clk,
   input  wire logic [31:0] reg_rdata,
   input  wire logic        reg_rvalid,
   // Requests
   output logic      [4:0]  reg_addr,
   output logic             reg_wr,
   output logic      [31:0] reg_wdata,
   output logic             reg_rd
);
   initial {reg_addr, reg_wr, reg_wdata, reg_rd} = '0;
   // Snapshot is written only when a caller means to
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      @(negedge core_clk);
      {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
      @(negedge core_clk);
      // Released data no longer shows the last value
      {reg_addr, reg_wdata, reg_wr} = {~a, ~d, 1'b0};
   endtask : wr
   task automatic rd(input logic [4:0] a, output logic [31:0] d);
      @(negedge core_clk);
      {reg_addr, reg_rd} = {a, 1'b1};
      @(negedge core_clk);
      {reg_addr, reg_rd} = {~a, 1'b0};
      d = reg_rvalid ? reg_rdata : 32'hx;
   endtask : rd
endmodule : host_model
`default_nettype wire

/* File: testbench/tb_top.sv */
// Bench for the snapshot and phase-delay register bank.
// Assumes host_model drives the register port.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   typedef struct packed {logic [4:0] a; logic [31:0] d, q;} row_t;
   logic        core_clk = 1'b0, sys_rst = 1'b1, modulator_clock = 1'b0;
   logic        reg_wr, reg_rd, reg_rvalid;
   logic [4:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, q, comparator_bit = 32'h0;
   logic [7:0]  channel_active = 8'h00, converter_reset, channel_start;
   logic [7:0]  acc = 8'h00, st[4] = '{8'h7b, 8'h00, 8'h04, 8'h00};
   logic [11:0] d67, d45, d23, d01;
   logic [23:0] ph0 = '0, ph1 = '0;
   int          miscompares = 0, n_checks = 0;
   row_t        rows[4] = '{'{5'h09, 32'habcdef12, 32'h00cdef12},
      '{5'h0a, 32'h12345678, 32'h00345678},
      '{5'h07, 32'hffffffff, 32'h0}, '{5'h0b, 32'h5a5a5a5a, 32'h0}};
   always #2 core_clk = ~core_clk;
   always @(posedge core_clk) acc <= acc | channel_start;
   modulator_phase_regs dut_u (.core_clk, .sys_rst, .reg_addr, .reg_wr,
      .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid, .modulator_clock,
      .comparator_bit, .channel_active, .converter_reset, .channel_start,
      .pair67_delay(d67), .pair45_delay(d45), .pair23_delay(d23),
      .pair01_delay(d01));
   host_model host_u (.core_clk, .reg_rdata, .reg_rvalid, .reg_addr,
      .reg_wr, .reg_wdata, .reg_rd);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic rchk(input logic [4:0] a, input logic [31:0] exp);
      host_u.rd(a, q);
      chk(q, exp);
   endtask : rchk
   task automatic tick(input logic [31:0] c);
      @(negedge core_clk);
      {comparator_bit, modulator_clock} = {c, 1'b1};
      @(negedge core_clk);
      {comparator_bit, modulator_clock} = {~c, 1'b0};
      repeat (3) @(negedge core_clk);
   endtask : tick
   task automatic give_verdict;
      $display("checks=%0d miscompares=%0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : give_verdict
   initial begin
      repeat (4) @(negedge core_clk);
      sys_rst = 1'b0;
      foreach (rows[i]) begin
         host_u.wr(rows[i].a, rows[i].d);
         if (rows[i].a == 5'h09) ph0 = rows[i].d[23:0];
         if (rows[i].a == 5'h0a) ph1 = rows[i].d[23:0];
         rchk(rows[i].a, rows[i].q);
         chk({8'h0, d67, d45}, {8'h0, ph0});
         chk({8'h0, d23, d01}, {8'h0, ph1});
      end
      tick(32'h76543210);
      rchk(5'h08, 32'h76543210);
      host_u.wr(5'h08, 32'hdeadbeef);
      rchk(5'h08, 32'hdeadbeef);
      tick(32'h0f1e2d3c);
      rchk(5'h08, 32'h0f1e2d3c);
      // Channel 7 idle; second write abandons the first restart
      channel_active = 8'h7f;
      host_u.wr(5'h09, 32'h0);
      chk({24'h0, converter_reset}, 32'h7f);
      host_u.wr(5'h0a, 32'h002000);
      chk({24'h0, converter_reset}, 32'h7f);
      foreach (st[k]) begin
         acc = 8'h00;
         tick(32'h33333333);
         chk({24'h0, acc}, {24'h0, st[k]});
      end
      sys_rst = 1'b1;
      repeat (4) @(negedge core_clk);
      sys_rst = 1'b0;
      rchk(5'h08, 32'h33333333);
      rchk(5'h09, 32'h0);
      rchk(5'h0a, 32'h0);
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
